//--- sfr_bank_consts.svh
// offsets, field positions and reset values of the upper-bank register map
`ifndef SFR_BANK_CONSTS_SVH
`define SFR_BANK_CONSTS_SVH

// printed data-memory offsets; the bus byte address is four times these
`define OFS_INDIRECT_B2 9'h100
`define OFS_TIMER0_B2 9'h101
`define OFS_PCLOW_B2 9'h102
`define OFS_FLAGS_B2 9'h103
`define OFS_POINTER_B2 9'h104
`define OFS_PORT_B_DATA_BANK2_DATA_B2 9'h106
`define OFS_LATCH_B2 9'h10A
`define OFS_INTCTRL_B2 9'h10B
`define OFS_INDIRECT_B3 9'h180
`define OFS_OPTION_B3 9'h181
`define OFS_PCLOW_B3 9'h182
`define OFS_FLAGS_B3 9'h183
`define OFS_POINTER_B3 9'h184
`define OFS_PORT_B_DATA_BANK2_DIR_B3 9'h186
`define OFS_LATCH_B3 9'h18A
`define OFS_INTCTRL_B3 9'h18B

// field positions in the core flags register
`define FLG_IRP 7
`define FLG_TO 4
`define FLG_PD 3

// widths
`define LATCH_W 5
`define PC_W 13

// reset values
`define RST_ZERO 8'h00
`define RST_FLAGS_POR 8'h18
`define RST_OPTION 8'hFF
`define RST_PORT_B_DATA_BANK2_DIR 8'hFF

`endif

//--- sfr_bank_pkg.sv
// types for the upper-bank register decode
package sfr_bank_pkg;

    typedef enum logic [10:0] {
        SEL_NONE     = 11'h001,
        SEL_INDIRECT = 11'h002,
        SEL_TIMER0   = 11'h004,
        SEL_OPTION   = 11'h008,
        SEL_PCLOW    = 11'h010,
        SEL_FLAGS    = 11'h020,
        SEL_POINTER  = 11'h040,
        SEL_PB_DATA  = 11'h080,
        SEL_PB_DIR   = 11'h100,
        SEL_LATCH    = 11'h200,
        SEL_INTCTRL  = 11'h400
    } reg_sel_e;

    typedef struct packed {
        logic [7:0] pb_meta;
        logic [7:0] pb_sync;
        logic [1:0] rst_meta;
        logic [1:0] rst_sync;
        logic [7:0] pointer;
        logic [4:0] latch;
        logic [12:0] pc;
        logic [7:0] flags;
        logic [7:0] intctrl;
        logic [7:0] timer0;
        logic [7:0] pb_latch;
        logic [7:0] pb_oe;
        logic [7:0] option;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } bank_state_s;

endpackage

//--- sfr_bank_two_three_map.sv
// special-function register decode for data-memory banks two and three, on APB
`include "sfr_bank_consts.svh"

module sfr_bank_two_three_map
    import sfr_bank_pkg::*;
(
    // clock and power-on reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // non power-up reset causes, asynchronous levels
    input wire logic external_reset_pin,
    input wire logic watchdog_reset,
    // program counter
    input wire logic pc_step,
    output logic [12:0] pc_out,
    // port b pins
    input wire logic [7:0] port_b_in,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe,
    // register contents for the core
    output logic [7:0] flags_out,
    output logic [7:0] option_out,
    output logic [7:0] interrupt_control_out
);

    bank_state_s st_r;
    bank_state_s st_nxt;

    logic [8:0] bus_index;
    logic bus_in_range;
    logic [8:0] indirect_addr;
    reg_sel_e direct_sel;
    reg_sel_e eff_sel;
    logic acc_take;
    logic wr_fire;
    logic other_reset;
    logic [7:0] rd_byte;

    function automatic reg_sel_e decode(input logic [8:0] a);
        reg_sel_e r;
        r = SEL_NONE;
        case (a)
            `OFS_INDIRECT_B2, `OFS_INDIRECT_B3: r = SEL_INDIRECT;
            `OFS_PCLOW_B2, `OFS_PCLOW_B3: r = SEL_PCLOW;
            `OFS_FLAGS_B2, `OFS_FLAGS_B3: r = SEL_FLAGS;
            `OFS_POINTER_B2, `OFS_POINTER_B3: r = SEL_POINTER;
            `OFS_LATCH_B2, `OFS_LATCH_B3: r = SEL_LATCH;
            `OFS_INTCTRL_B2, `OFS_INTCTRL_B3: r = SEL_INTCTRL;
            `OFS_TIMER0_B2: r = SEL_TIMER0;
            `OFS_OPTION_B3: r = SEL_OPTION;
            `OFS_PORT_B_DATA_BANK2_DATA_B2: r = SEL_PB_DATA;
            `OFS_PORT_B_DATA_BANK2_DIR_B3: r = SEL_PB_DIR;
            default: r = SEL_NONE;
        endcase
        return r;
    endfunction

    // misaligned or out-of-window bus addresses fall into the unmapped case
    assign bus_index = paddr[10:2];
    assign bus_in_range = (paddr[11] == 1'b0) && (paddr[1:0] == 2'b00);
    assign direct_sel = bus_in_range ? decode(bus_index) : SEL_NONE;
    assign indirect_addr = {st_r.flags[`FLG_IRP], st_r.pointer};

    // a pointer aimed at the indirect location itself reaches nothing
    always_comb begin
        eff_sel = direct_sel;
        if (direct_sel == SEL_INDIRECT) begin
            eff_sel = decode(indirect_addr);
            if (eff_sel == SEL_INDIRECT) begin
                eff_sel = SEL_NONE;
            end
        end
    end

    assign acc_take = psel && penable && !st_r.pready;
    // writes land on the edge where the master sees pready high
    assign wr_fire = psel && penable && pwrite && st_r.pready;
    assign other_reset = |st_r.rst_sync;

    always_comb begin
        case (eff_sel)
            SEL_TIMER0: rd_byte = st_r.timer0;
            SEL_OPTION: rd_byte = st_r.option;
            SEL_PCLOW: rd_byte = st_r.pc[7:0];
            SEL_FLAGS: rd_byte = st_r.flags;
            SEL_POINTER: rd_byte = st_r.pointer;
            SEL_PB_DATA: rd_byte = st_r.pb_sync;
            SEL_PB_DIR: rd_byte = ~st_r.pb_oe;
            SEL_LATCH: rd_byte = {3'h0, st_r.latch};
            SEL_INTCTRL: rd_byte = st_r.intctrl;
            default: rd_byte = `RST_ZERO;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        // pins and reset causes pass two flops before use
        st_nxt.pb_meta = port_b_in;
        st_nxt.pb_sync = st_r.pb_meta;
        st_nxt.rst_meta = {external_reset_pin, watchdog_reset};
        st_nxt.rst_sync = st_r.rst_meta;
        if (pc_step) begin
            st_nxt.pc = st_r.pc + 13'h0001;
        end
        // one wait state: data is fetched on the first access edge
        st_nxt.pready = acc_take;
        // every location answers; unmapped ones read zero instead of raising an error
        st_nxt.pslverr = 1'b0;
        if (acc_take) begin
            st_nxt.prdata = {24'h000000, rd_byte};
        end
        if (wr_fire) begin
            case (eff_sel)
                SEL_TIMER0: st_nxt.timer0 = pwdata[7:0];
                SEL_OPTION: st_nxt.option = pwdata[7:0];
                SEL_PCLOW: st_nxt.pc = {st_r.latch, pwdata[7:0]};
                SEL_FLAGS: begin
                    // timeout and power-down bits are read-only
                    st_nxt.flags = pwdata[7:0];
                    st_nxt.flags[`FLG_TO] = st_r.flags[`FLG_TO];
                    st_nxt.flags[`FLG_PD] = st_r.flags[`FLG_PD];
                end
                SEL_POINTER: st_nxt.pointer = pwdata[7:0];
                SEL_PB_DATA: st_nxt.pb_latch = pwdata[7:0];
                SEL_PB_DIR: st_nxt.pb_oe = ~pwdata[7:0];
                SEL_LATCH: st_nxt.latch = pwdata[`LATCH_W-1:0];
                SEL_INTCTRL: st_nxt.intctrl = pwdata[7:0];
                default: ;
            endcase
        end
        // other resets win over a bus write or pc step in the same cycle, for the fields they reset
        if (other_reset) begin
            st_nxt.pc = 13'h0000;
            st_nxt.latch = 5'h00;
            st_nxt.option = `RST_OPTION;
            st_nxt.pb_oe = ~`RST_PORT_B_DATA_BANK2_DIR;
            st_nxt.flags[7:5] = 3'h0;
            st_nxt.intctrl[7:1] = 7'h00;
            // watchdog clears the timeout bit, the reset pin leaves both alone
            if (st_r.rst_sync[0]) begin
                st_nxt.flags[`FLG_TO] = 1'b0;
                st_nxt.flags[`FLG_PD] = 1'b1;
            end
        end
    end

    // unknown power-on bits are given zero so simulation stays defined
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.flags <= `RST_FLAGS_POR;
            st_r.option <= `RST_OPTION;
            st_r.pb_oe <= ~`RST_PORT_B_DATA_BANK2_DIR;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign pc_out = st_r.pc;
    assign port_b_out = st_r.pb_latch;
    assign port_b_oe = st_r.pb_oe;
    assign flags_out = st_r.flags;
    assign option_out = st_r.option;
    assign interrupt_control_out = st_r.intctrl;

    sequence s_access_first;
        psel && penable && !pready;
    endsequence

    sequence s_access_done;
        psel && penable && pready;
    endsequence

    // a flags write through bank three, an idle and a setup cycle, then a bank two read
    sequence s_flags_wr_b3;
        s_access_done ##0 (pwrite && bus_in_range && !other_reset
            && bus_index == `OFS_FLAGS_B3);
    endsequence

    sequence s_quiet_gap;
        (!other_reset)[*2];
    endsequence

    sequence s_flags_rd_b2;
        acc_take && !pwrite && bus_in_range && !other_reset && bus_index == `OFS_FLAGS_B2;
    endsequence

    // a reset cause held long enough to pass both synchroniser flops
    sequence s_cause_held;
        (external_reset_pin || watchdog_reset)[*3];
    endsequence

    a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
        s_access_first |=> pready ##1 !pready)
        else $error("pready did not pulse one cycle after access");

    a_unmapped_read_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        (acc_take && !pwrite && eff_sel == SEL_NONE) |=> (prdata == 32'h00000000))
        else $error("unmapped location read nonzero");

    a_pc_load_latch: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && eff_sel == SEL_PCLOW && !other_reset)
        |=> (pc_out == {$past(st_r.latch), $past(pwdata[7:0])}))
        else $error("pc load did not take latch bits");

    a_pc_high_hidden: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && eff_sel == SEL_LATCH && !pc_step && !other_reset) |=> $stable(pc_out))
        else $error("latch write changed pc directly");

    a_flags_mirror: assert property (
        @(posedge pclk) disable iff (!presetn)
        (s_flags_wr_b3 ##1 s_quiet_gap ##1 s_flags_rd_b2)
        |=> (prdata[7:5] == $past(pwdata[7:5], 4)))
        else $error("bank copies of flags differ");

    a_other_reset_vals: assert property (
        @(posedge pclk) disable iff (!presetn)
        other_reset |=> (pc_out == 13'h0000 && option_out == `RST_OPTION
            && port_b_oe == 8'h00))
        else $error("other reset values wrong");

    a_unchanged_bits: assert property (
        @(posedge pclk) disable iff (!presetn)
        (other_reset && !wr_fire) |=> ($stable(st_r.pointer) && $stable(flags_out[2:0])
            && $stable(interrupt_control_out[0]) && $stable(port_b_out)))
        else $error("unchanged bits moved during reset");

    a_indirect_target: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && direct_sel == SEL_INDIRECT && eff_sel == SEL_OPTION && !other_reset)
        |=> (option_out == $past(pwdata[7:0])))
        else $error("indirect write missed pointer target");

    a_unmapped_write_lost: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && eff_sel == SEL_NONE && !other_reset && !pc_step)
        |=> ($stable(pc_out) && $stable(flags_out) && $stable(option_out)
            && $stable(interrupt_control_out) && $stable(port_b_out) && $stable(port_b_oe)
            && $stable(st_r.pointer) && $stable(st_r.latch) && $stable(st_r.timer0)))
        else $error("unmapped write changed a register");

    a_upper_bits_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_access_done |-> (prdata[31:8] == 24'h000000))
        else $error("read data above the byte not zero");

    a_latch_read_back: assert property (
        @(posedge pclk) disable iff (!presetn)
        (acc_take && !pwrite && eff_sel == SEL_LATCH)
        |=> (prdata == {27'h0000000, $past(st_r.latch)}))
        else $error("latch read did not return five bits");

    a_pc_step_inc: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pc_step && !other_reset && !(wr_fire && eff_sel == SEL_PCLOW))
        |=> (pc_out == $past(pc_out) + 13'h0001))
        else $error("program counter step lost");

    a_pc_low_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        (acc_take && !pwrite && eff_sel == SEL_PCLOW)
        |=> (prdata == {24'h000000, $past(pc_out[7:0])}))
        else $error("pc low read did not return the low byte");

    a_mirror_pointer: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && bus_in_range
            && (bus_index == `OFS_POINTER_B2 || bus_index == `OFS_POINTER_B3))
        |=> (st_r.pointer == $past(pwdata[7:0])))
        else $error("pointer copies do not share storage");

    a_reset_high_bits: assert property (
        @(posedge pclk) disable iff (!presetn)
        other_reset |=> (st_r.latch == 5'h00 && flags_out[7:5] == 3'h0
            && interrupt_control_out[7:1] == 7'h00))
        else $error("other reset left high bits set");

    // the cause is only seen after two flops, so the effect lags the pin by three edges
    a_cause_to_effect: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_cause_held |=> (pc_out == 13'h0000 && option_out == `RST_OPTION))
        else $error("reset cause not applied after the synchroniser");

    a_watchdog_flags: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_r.rst_sync[0] |=> (flags_out[`FLG_TO] == 1'b0 && flags_out[`FLG_PD] == 1'b1))
        else $error("watchdog reset left timeout or power-down bit wrong");

    a_pin_keeps_flags: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.rst_sync == 2'b10) |=> $stable(flags_out[`FLG_TO:`FLG_PD]))
        else $error("reset pin moved timeout or power-down bit");

    a_flags_ro_bits: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && eff_sel == SEL_FLAGS && !other_reset)
        |=> $stable(flags_out[`FLG_TO:`FLG_PD]))
        else $error("bus write moved timeout or power-down bit");

    a_timer_kept: assert property (
        @(posedge pclk) disable iff (!presetn)
        (other_reset && !wr_fire) |=> $stable(st_r.timer0))
        else $error("timer count moved during other reset");

    a_indirect_self_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        (acc_take && !pwrite && direct_sel == SEL_INDIRECT
            && (indirect_addr == `OFS_INDIRECT_B2 || indirect_addr == `OFS_INDIRECT_B3))
        |=> (prdata == 32'h00000000))
        else $error("indirect location reached itself");

    // the lower banks live outside this block, so those targets read as nothing here
    a_indirect_low_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        (acc_take && !pwrite && direct_sel == SEL_INDIRECT && !flags_out[`FLG_IRP])
        |=> (prdata == 32'h00000000))
        else $error("indirect read outside the banks returned data");

    a_pready_idle: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(psel && penable) |=> !pready)
        else $error("pready raised without an access");

endmodule

//--- tb.sv
// self-checking bench for the upper-bank register decode, with a reference model
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic external_reset_pin = 0, watchdog_reset = 0, pc_step = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd_v, rs = 32'hEFF4CD4F;
    logic pready, pslverr;
    logic [7:0] port_b_in = 0, port_b_out, port_b_oe, flags_out, option_out, intc_out;
    logic [12:0] pc_out;
    int fail_count = 0, cmp_count = 0;
    int m_tmr, m_opt, m_pc, m_flg, m_ptr, m_pbo, m_dir, m_lat, m_int;
    int regs[16] = '{'h100, 'h101, 'h102, 'h103, 'h104, 'h106, 'h10A, 'h10B,
        'h180, 'h181, 'h182, 'h183, 'h184, 'h186, 'h18A, 'h18B};
    int unm[7] = '{'h105, 'h107, 'h109, 'h10C, 'h17F, 'h185, 'h18C};
    int mir[4] = '{'h103, 'h104, 'h10A, 'h10B};

    sfr_bank_two_three_map u_sfr_bank_two_three_map (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_reset_pin(external_reset_pin), .watchdog_reset(watchdog_reset),
        .pc_step(pc_step), .pc_out(pc_out), .port_b_in(port_b_in), .port_b_out(port_b_out),
        .port_b_oe(port_b_oe), .flags_out(flags_out), .option_out(option_out),
        .interrupt_control_out(intc_out));

    always #50 pclk = ~pclk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function int rnd();
        rs = lfsr(rs);
        return int'(rs[7:0]);
    endfunction

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // the indirect location stands for {irp, pointer}
    function automatic int tgt(int i);
        if (i == 'h100 || i == 'h180)
            return ((m_flg >> 7) << 8) | m_ptr;
        return i;
    endfunction

    function automatic int mrd(int i);
        case (tgt(i))
            'h101: return m_tmr;
            'h181: return m_opt;
            'h102, 'h182: return m_pc & 'hFF;
            'h103, 'h183: return m_flg;
            'h104, 'h184: return m_ptr;
            'h106: return int'(port_b_in);
            'h186: return m_dir;
            'h10A, 'h18A: return m_lat;
            'h10B, 'h18B: return m_int;
            default: return 0;
        endcase
    endfunction

    task mwr(int i, int d);
        case (tgt(i))
            'h101: m_tmr = d;
            'h181: m_opt = d;
            'h102, 'h182: m_pc = (m_lat << 8) | d;
            'h103, 'h183: m_flg = (m_flg & 'h18) | (d & 'hE7);
            'h104, 'h184: m_ptr = d;
            'h106: m_pbo = d;
            'h186: m_dir = d;
            'h10A, 'h18A: m_lat = d & 'h1F;
            'h10B, 'h18B: m_int = d;
            default: ;
        endcase
    endtask

    // called right after a rising edge; returns one edge after the release
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n == 20) begin
            fail_count++;
            test_done;
        end
        rd_v = prdata;
        chk(32'(pslverr), 32'h0);
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask

    task wr(int i, int d);
        apb(1'b1, 12'(i * 4), 32'(d));
        mwr(i, d);
    endtask

    task rd(int i);
        apb(1'b0, 12'(i * 4), 32'h0);
        chk(rd_v, 32'(mrd(i)));
    endtask

    task outs;
        chk(32'(pc_out), 32'(m_pc));
        chk(32'(flags_out), 32'(m_flg));
        chk(32'(option_out), 32'(m_opt));
        chk(32'(intc_out), 32'(m_int));
        chk(32'(port_b_oe), 32'(~m_dir & 'hFF));
        chk(32'(port_b_out), 32'(m_pbo));
    endtask

    // power-on values, unknown bits taken as zero like the design
    task mreset;
        {m_tmr, m_pc, m_ptr, m_pbo, m_lat, m_int} = '0;
        m_opt = 'hFF;
        m_dir = 'hFF;
        m_flg = 'h18;
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // generous: the whole sequence needs about a thousand cycles
    initial begin
        #2000000;
        fail_count++;
        test_done;
    end

    initial begin
        mreset;
        repeat (12) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        outs;
        foreach (regs[k]) rd(regs[k]);
        $display("reset values done");
        foreach (unm[k]) begin
            wr(unm[k], rnd());
            rd(unm[k]);
        end
        apb(1'b1, 12'hC0C, 32'hFF);
        apb(1'b0, 12'hC0C, 32'h0);
        chk(rd_v, 32'h0);
        apb(1'b0, 12'h40D, 32'h0);
        chk(rd_v, 32'h0);
        foreach (regs[k]) rd(regs[k]);
        $display("unmapped done");
        foreach (mir[k]) begin
            wr(mir[k], rnd());
            rd(mir[k] + 'h80);
            wr(mir[k] + 'h80, rnd());
            rd(mir[k]);
        end
        foreach (regs[k]) wr(regs[k], rnd());
        foreach (regs[k]) rd(regs[k]);
        $display("mirror done");
        wr('h18A, rnd());
        wr('h102, 'hFF);
        outs;
        pc_step <= 1;
        @(posedge pclk);
        pc_step <= 0;
        m_pc = (m_pc + 1) & 'h1FFF;
        @(posedge pclk);
        chk(pc_out, 32'(m_pc));
        rd('h182);
        $display("program counter done");
        foreach (regs[k]) begin
            wr('h103, 'h80);
            wr('h104, regs[k] & 'hFF);
            rd('h100);
        end
        wr('h184, 'h0B);
        wr('h180, rnd());
        rd('h18B);
        wr('h184, 'h81);
        wr('h100, rnd());
        rd('h181);
        wr('h103, 'h00);
        rd('h180);
        $display("indirect done");
        port_b_in <= 8'(rnd());
        repeat (3) @(posedge pclk);
        rd('h106);
        wr('h106, rnd());
        // the other-reset sources are exercised in turn: watchdog first, then the pin
        for (int r = 0; r < 2; r++) begin
            foreach (regs[k]) wr(regs[k], rnd());
            if (r == 0) watchdog_reset <= 1;
            else external_reset_pin <= 1;
            repeat (5) @(posedge pclk);
            watchdog_reset <= 0;
            external_reset_pin <= 0;
            repeat (4) @(posedge pclk);
            {m_pc, m_lat} = '0;
            m_opt = 'hFF;
            m_dir = 'hFF;
            m_int = m_int & 1;
            m_flg = (r == 0) ? ((m_flg & 'h07) | 'h08) : (m_flg & 'h1F);
            outs;
            foreach (regs[k]) rd(regs[k]);
        end
        $display("other resets done");
        // power-on reset again, after the watchdog has moved the timeout bits
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        mreset;
        @(posedge pclk);
        outs;
        foreach (regs[k]) rd(regs[k]);
        $display("second power-on reset done");
        test_done;
    end
endmodule
